/* File: hdl/ssef_pkg.sv */
// Purpose: Shared constants for the serial status and error flag block
// Assumes: 8-bit CPU register port, byte addresses
// Notes:   Bit positions are the same for read data and write data

package ssef_pkg;

  // Register addresses
  localparam logic [15:0] SSEF_ADDR_CONTROL_TWO   = 16'h0014;
  localparam logic [15:0] SSEF_ADDR_CONTROL_THREE = 16'h0015;
  localparam logic [15:0] SSEF_ADDR_STATUS_ONE    = 16'h0016;
  localparam logic [15:0] SSEF_ADDR_STATUS_TWO    = 16'h0017;
  localparam logic [15:0] SSEF_ADDR_DATA_BUFFER   = 16'h0018;

  // Control two fields
  localparam int SSEF_C2_TXE_IE  = 7;
  localparam int SSEF_C2_TC_IE   = 6;
  localparam int SSEF_C2_RXF_IE  = 5;
  localparam int SSEF_C2_IDLE_IE = 4;

  // Control three fields
  localparam int SSEF_C3_RX_BIT8 = 7;
  localparam int SSEF_C3_TX_BIT8 = 6;
  localparam int SSEF_C3_OVR_IE  = 3;
  localparam int SSEF_C3_NOISE_IE = 2;
  localparam int SSEF_C3_FRAME_IE = 1;
  localparam int SSEF_C3_PAR_IE  = 0;

  // Status one fields
  localparam int SSEF_S1_TXE   = 7;
  localparam int SSEF_S1_TC    = 6;
  localparam int SSEF_S1_RXF   = 5;
  localparam int SSEF_S1_IDLE  = 4;
  localparam int SSEF_S1_OVR   = 3;
  localparam int SSEF_S1_NOISE = 2;
  localparam int SSEF_S1_FRAME = 1;
  localparam int SSEF_S1_PAR   = 0;

  // Status two fields
  localparam int SSEF_S2_BREAK = 1;
  localparam int SSEF_S2_RPF   = 0;

  // Reset values
  localparam logic       SSEF_RST_SET   = 1'b1;
  localparam logic       SSEF_RST_CLR   = 1'b0;
  localparam logic [7:0] SSEF_BYTE_ZERO = 8'h00;
  localparam logic [3:0] SSEF_NIB_ZERO  = 4'h0;

endpackage : ssef_pkg

/* File: hdl/ssef_flag_cell.sv */
// Purpose: One clearable sticky flag with a read-then-access clear sequence
// Assumes: Snapshot and clear access never fall in the same cycle
// Notes:   A set in the clearing cycle wins over the clear

`timescale 1ns/100ps

module ssef_flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic set_evt,
  input  wire logic snap_evt,
  input  wire logic clear_evt,
  output logic      flag
);

  logic seen;

  // Remember whether the flag stood at the status read
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      seen <= 1'b0;
    end else if (snap_evt) begin
      seen <= flag;
    end else if (clear_evt) begin
      seen <= 1'b0;
    end
  end

  // Only a flag seen at the status read is cleared; late sets survive
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flag <= RESET_VAL;
    end else if (set_evt) begin
      flag <= 1'b1;
    end else if (clear_evt && seen) begin
      flag <= 1'b0;
    end
  end

endmodule : ssef_flag_cell

/* File: hdl/ssef_status_flags.sv */
// Purpose: Status, error flags and data buffer of an asynchronous serial unit
// Assumes: Datapath events are one-cycle pulses synchronous to mclk
// Notes:   Baud generation and shift registers live outside this block
//
// Summary of operation
// - Four reset-cleared enables gate overrun, noise, framing, parity onto error request.
// - Tx-empty set on buffer hand-off and by reset; status read then write clears.
// - Tx-complete set while empty and idle, reset sets, clears when anything queued.
// - Line may start up to 1.5 transmitter clocks after queuing.
// - Rx-full set when a character loads; reset clears; status then data read clears.
// - Idle set after 10 or 11 ones; interrupt when enabled; read sequence clears.
// - Idle stays unarmed after enabling or clearing until a character sets rx-full.
// - Character during rx-full sets overrun, is discarded, buffer kept.
// - Data read clears overrun only if overrun stood at the status read.
// - Noise flag set on line noise, interrupts when enabled, read sequence clears.
// - Framing flag set on zero stop bit, interrupts when enabled, read sequence clears.
// - Parity flag set on parity failure, interrupts when enabled, read sequence clears.
// - Break sets break, framing and rx-full, clears ninth bit; the break flag itself has no interrupt.
// - Status two then data read clears break; rearms only after ones seen.
// - In-progress flag set by zero at first sample slot, cleared on false start or idle.
// - One data address reads received byte and writes transmit byte; reset leaves it.

`timescale 1ns/100ps

module ssef_status_flags
  import ssef_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // CPU register port
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_rd,
  input  wire logic        cpu_wr,
  input  wire logic [7:0]  cpu_wdata,
  output logic [7:0]       cpu_rdata,
  // Configuration from the other control registers
  input  wire logic        rx_enable,
  input  wire logic        nine_bit_mode,
  // Receive datapath events
  input  wire logic        rx_char_done,
  input  wire logic [7:0]  rx_char_data,
  input  wire logic        rx_char_bit8,
  input  wire logic        rx_noise,
  input  wire logic        rx_frame_err,
  input  wire logic        rx_parity_err,
  input  wire logic        rx_break,
  input  wire logic        rx_line_high,
  input  wire logic        rx_idle_char,
  input  wire logic        rx_start_seen,
  input  wire logic        rx_false_start,
  // Transmit datapath
  input  wire logic        tx_load_taken,
  input  wire logic        tx_busy,
  input  wire logic        tx_queued,
  output logic [7:0]       tx_data_out,
  output logic             tx_ninth_out,
  output logic             tx_data_valid,
  // Interrupt requests and received ninth bit
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             rx_err_irq,
  output logic             rx_ninth_bit
);

  // Address compare used by every access decode
  function automatic logic ssef_hit(input logic [15:0] a, input logic [15:0] off);
    ssef_hit = (a == off);
  endfunction : ssef_hit

  logic [3:0] ctl_two;
  logic [3:0] err_enables;
  logic [7:0] rx_buffer;
  logic       tx_empty_flag, tx_complete_flag, rx_full_flag, idle_flag;
  logic       overrun_flag, noise_flag, framing_error_flag, parity_error_flag;
  logic       break_detect_flag, rx_in_progress_flag;
  logic       idle_armed, break_armed, rx_enable_q, idle_q;
  logic       overrun_irq_enable, noise_irq_enable, framing_irq_enable, parity_irq_enable;
  logic       tx_empty_irq_enable, tx_complete_irq_enable, rx_full_irq_enable;
  logic       idle_irq_enable;
  logic       rd_s1, rd_s2, rd_data, wr_data, wr_c2, wr_c3;
  logic       brk_evt, accept, ovr_evt, idle_set;

  // Access decode
  assign rd_s1   = cpu_rd && ssef_hit(cpu_addr, SSEF_ADDR_STATUS_ONE);
  assign rd_s2   = cpu_rd && ssef_hit(cpu_addr, SSEF_ADDR_STATUS_TWO);
  assign rd_data = cpu_rd && ssef_hit(cpu_addr, SSEF_ADDR_DATA_BUFFER);
  assign wr_data = cpu_wr && ssef_hit(cpu_addr, SSEF_ADDR_DATA_BUFFER);
  assign wr_c2   = cpu_wr && ssef_hit(cpu_addr, SSEF_ADDR_CONTROL_TWO);
  assign wr_c3   = cpu_wr && ssef_hit(cpu_addr, SSEF_ADDR_CONTROL_THREE);

  // Field aliases
  assign tx_empty_irq_enable    = ctl_two[SSEF_C2_TXE_IE - SSEF_C2_IDLE_IE];
  assign tx_complete_irq_enable = ctl_two[SSEF_C2_TC_IE - SSEF_C2_IDLE_IE];
  assign rx_full_irq_enable     = ctl_two[SSEF_C2_RXF_IE - SSEF_C2_IDLE_IE];
  assign idle_irq_enable        = ctl_two[SSEF_C2_IDLE_IE - SSEF_C2_IDLE_IE];
  assign overrun_irq_enable     = err_enables[SSEF_C3_OVR_IE];
  assign noise_irq_enable       = err_enables[SSEF_C3_NOISE_IE];
  assign framing_irq_enable     = err_enables[SSEF_C3_FRAME_IE];
  assign parity_irq_enable      = err_enables[SSEF_C3_PAR_IE];

  // Receive events; a break counts only once the line has shown ones again
  assign brk_evt  = rx_break && break_armed;
  assign accept   = (rx_char_done || brk_evt) && !rx_full_flag;
  assign ovr_evt  = rx_char_done && rx_full_flag;
  assign idle_set = rx_idle_char && idle_armed;

  // Interrupt enable registers, all cleared by reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctl_two     <= SSEF_NIB_ZERO;
      err_enables <= SSEF_NIB_ZERO;
    end else begin
      if (wr_c2) begin
        ctl_two <= cpu_wdata[SSEF_C2_TXE_IE:SSEF_C2_IDLE_IE];
      end
      if (wr_c3) begin
        err_enables <= cpu_wdata[SSEF_C3_OVR_IE:SSEF_C3_PAR_IE];
      end
    end
  end

  // Transmit ninth bit
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_ninth_out <= SSEF_RST_CLR;
    end else if (wr_c3) begin
      tx_ninth_out <= cpu_wdata[SSEF_C3_TX_BIT8];
    end
  end

  // Data buffers: separate receive and transmit storage, untouched by reset
  always_ff @(posedge mclk) begin
    if (wr_data) begin
      tx_data_out <= cpu_wdata;
    end
    if (accept) begin
      rx_buffer <= brk_evt ? SSEF_BYTE_ZERO : rx_char_data;
    end
  end

  // Received ninth bit; in 8-bit mode it mirrors bit 7
  // A break loads zeros, so the ninth bit clears in either mode
  always_ff @(posedge mclk) begin
    if (accept) begin
      if (brk_evt) begin
        rx_ninth_bit <= SSEF_RST_CLR;
      end else begin
        rx_ninth_bit <= nine_bit_mode ? rx_char_bit8 : rx_char_data[7];
      end
    end
  end

  // Sticky flags with their read-then-access clear sequences
  ssef_flag_cell #(.RESET_VAL(SSEF_RST_SET)) u_txe (
    .mclk(mclk), .sys_rst(sys_rst), .set_evt(tx_load_taken), .snap_evt(rd_s1),
    .clear_evt(wr_data), .flag(tx_empty_flag));
  ssef_flag_cell #(.RESET_VAL(SSEF_RST_CLR)) u_rxf (
    .mclk(mclk), .sys_rst(sys_rst), .set_evt(accept), .snap_evt(rd_s1),
    .clear_evt(rd_data), .flag(rx_full_flag));
  ssef_flag_cell #(.RESET_VAL(SSEF_RST_CLR)) u_idle (
    .mclk(mclk), .sys_rst(sys_rst), .set_evt(idle_set), .snap_evt(rd_s1),
    .clear_evt(rd_data), .flag(idle_flag));
  ssef_flag_cell #(.RESET_VAL(SSEF_RST_CLR)) u_ovr (
    .mclk(mclk), .sys_rst(sys_rst), .set_evt(ovr_evt), .snap_evt(rd_s1),
    .clear_evt(rd_data), .flag(overrun_flag));
  ssef_flag_cell #(.RESET_VAL(SSEF_RST_CLR)) u_noise (
    .mclk(mclk), .sys_rst(sys_rst), .set_evt(rx_noise), .snap_evt(rd_s1),
    .clear_evt(rd_data), .flag(noise_flag));
  ssef_flag_cell #(.RESET_VAL(SSEF_RST_CLR)) u_frame (
    .mclk(mclk), .sys_rst(sys_rst), .set_evt(rx_frame_err || brk_evt), .snap_evt(rd_s1),
    .clear_evt(rd_data), .flag(framing_error_flag));
  ssef_flag_cell #(.RESET_VAL(SSEF_RST_CLR)) u_par (
    .mclk(mclk), .sys_rst(sys_rst), .set_evt(rx_parity_err), .snap_evt(rd_s1),
    .clear_evt(rd_data), .flag(parity_error_flag));
  ssef_flag_cell #(.RESET_VAL(SSEF_RST_CLR)) u_brk (
    .mclk(mclk), .sys_rst(sys_rst), .set_evt(brk_evt), .snap_evt(rd_s2),
    .clear_evt(rd_data), .flag(break_detect_flag));

  // Transmission complete follows the empty and idle state, drops on any queue
  // Start on the line may lag by up to 1.5 bit clocks, so clear at queue time
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_complete_flag <= SSEF_RST_SET;
    end else if (wr_data || tx_queued) begin
      tx_complete_flag <= 1'b0;
    end else begin
      tx_complete_flag <= tx_empty_flag && !tx_busy;
    end
  end

  // Edge history for idle arming
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_enable_q <= SSEF_RST_CLR;
      idle_q      <= SSEF_RST_CLR;
    end else begin
      rx_enable_q <= rx_enable;
      idle_q      <= idle_flag;
    end
  end

  // Idle detection armed only by an accepted character
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      idle_armed <= SSEF_RST_CLR;
    end else if (accept && rx_char_done) begin
      idle_armed <= 1'b1;
    end else if ((rx_enable && !rx_enable_q) || (idle_q && !idle_flag) || idle_set) begin
      idle_armed <= 1'b0;
    end
  end

  // Break rearm needs ones on the line; a stuck-low line gives one break only
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      break_armed <= SSEF_RST_SET;
    end else if (brk_evt) begin
      break_armed <= 1'b0;
    end else if (rx_line_high) begin
      break_armed <= 1'b1;
    end
  end

  // Reception in progress; a new start wins over a same-cycle clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_in_progress_flag <= SSEF_RST_CLR;
    end else if (rx_start_seen) begin
      rx_in_progress_flag <= 1'b1;
    end else if (rx_false_start || rx_idle_char) begin
      rx_in_progress_flag <= 1'b0;
    end
  end

  // Read data, registered; unmapped addresses read as zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cpu_rdata <= SSEF_BYTE_ZERO;
    end else if (cpu_rd) begin
      cpu_rdata <= SSEF_BYTE_ZERO;
      case (cpu_addr)
        SSEF_ADDR_CONTROL_TWO: begin
          cpu_rdata[SSEF_C2_TXE_IE:SSEF_C2_IDLE_IE] <= ctl_two;
        end
        SSEF_ADDR_CONTROL_THREE: begin
          cpu_rdata[SSEF_C3_RX_BIT8]               <= rx_ninth_bit;
          cpu_rdata[SSEF_C3_TX_BIT8]               <= tx_ninth_out;
          cpu_rdata[SSEF_C3_OVR_IE:SSEF_C3_PAR_IE] <= err_enables;
        end
        SSEF_ADDR_STATUS_ONE: begin
          cpu_rdata[SSEF_S1_TXE]   <= tx_empty_flag;
          cpu_rdata[SSEF_S1_TC]    <= tx_complete_flag;
          cpu_rdata[SSEF_S1_RXF]   <= rx_full_flag;
          cpu_rdata[SSEF_S1_IDLE]  <= idle_flag;
          cpu_rdata[SSEF_S1_OVR]   <= overrun_flag;
          cpu_rdata[SSEF_S1_NOISE] <= noise_flag;
          cpu_rdata[SSEF_S1_FRAME] <= framing_error_flag;
          cpu_rdata[SSEF_S1_PAR]   <= parity_error_flag;
        end
        SSEF_ADDR_STATUS_TWO: begin
          cpu_rdata[SSEF_S2_BREAK] <= break_detect_flag;
          cpu_rdata[SSEF_S2_RPF]   <= rx_in_progress_flag;
        end
        SSEF_ADDR_DATA_BUFFER: begin
          cpu_rdata <= rx_buffer;
        end
        default: begin
          cpu_rdata <= SSEF_BYTE_ZERO;
        end
      endcase
    end
  end

  // Interrupt requests; break and in-progress flags never interrupt
  assign tx_data_valid = !tx_empty_flag;
  assign tx_irq     = (tx_empty_flag && tx_empty_irq_enable)
                   || (tx_complete_flag && tx_complete_irq_enable);
  assign rx_irq     = (rx_full_flag && rx_full_irq_enable)
                   || (idle_flag && idle_irq_enable);
  assign rx_err_irq = (overrun_flag && overrun_irq_enable)
                   || (noise_flag && noise_irq_enable)
                   || (framing_error_flag && framing_irq_enable)
                   || (parity_error_flag && parity_irq_enable);

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_err_irq_gate: assert property (!rx_err_irq |-> !(overrun_flag && overrun_irq_enable)
    && !(parity_error_flag && parity_irq_enable))
    else $error("error request missing for enabled flag");
  a_txe_set: assert property (tx_load_taken |=> tx_empty_flag)
    else $error("tx empty not set after hand-off");
  a_tc_queue: assert property ((wr_data || tx_queued) |=> !tx_complete_flag)
    else $error("tx complete not cleared on queue");
  a_rxf_load: assert property ((rx_char_done && !rx_full_flag && !rx_break)
    |=> rx_full_flag && rx_buffer == $past(rx_char_data))
    else $error("receive load wrong");
  a_ovr_keep: assert property (ovr_evt |=> overrun_flag && $stable(rx_buffer))
    else $error("overrun did not keep buffer");
  a_idle_unarmed: assert property ((!idle_armed && !idle_flag) |=> !idle_flag)
    else $error("idle set while unarmed");
  a_brk_rearm: assert property ((!break_armed && !break_detect_flag)
    |=> !break_detect_flag)
    else $error("break set without rearm");
  a_brk_sets: assert property (brk_evt && !rx_full_flag
    |=> break_detect_flag && framing_error_flag && rx_full_flag)
    else $error("break side flags missing");
  a_rpf_start: assert property (rx_start_seen |=> rx_in_progress_flag [*1] ##0 1)
    else $error("in-progress not set");
  a_fe_set: assert property (rx_frame_err |=> framing_error_flag)
    else $error("framing flag not set");

endmodule : ssef_status_flags

/* File: bench/ssef_rx_node.sv */
// Purpose: Remote serial node model feeding the receive event lines
// Assumes: Events are one-cycle pulses launched just after a rising edge
// Notes:   Data lines show the inverse once unqualified, never a stale copy

`timescale 1ns/100ps

module ssef_rx_node (
  input  wire logic       mclk,
  output logic            rx_char_done,
  output logic [7:0]      rx_char_data,
  output logic            rx_char_bit8,
  output logic            rx_noise,
  output logic            rx_frame_err,
  output logic            rx_parity_err,
  output logic            rx_break,
  output logic            rx_line_high,
  output logic            rx_idle_char,
  output logic            rx_start_seen,
  output logic            rx_false_start
);
  logic [8:0] ev_r = 9'h000;

  // Event order: done, noise, frame, parity, break, ones, idle, start, false start
  assign {rx_char_done, rx_noise, rx_frame_err, rx_parity_err, rx_break,
          rx_line_high, rx_idle_char, rx_start_seen, rx_false_start} = ev_r;

  initial begin
    rx_char_data = 8'h00;
    rx_char_bit8 = 1'b0;
  end

  // One event cycle, then the data lines stop meaning anything
  task automatic pulse(input logic [8:0] e, input logic [7:0] d, input logic b8);
    @(posedge mclk);
    ev_r         <= e;
    rx_char_data <= d;
    rx_char_bit8 <= b8;
    @(posedge mclk);
    ev_r         <= 9'h000;
    rx_char_data <= ~d;
    rx_char_bit8 <= ~b8;
  endtask : pulse
endmodule : ssef_rx_node

/* File: bench/ssef_status_flags_tb_top.sv */
// Purpose: Self-checking bench for the serial status and error flag block
// Assumes: Read data settles one cycle after the read edge
// Notes:   Drivers queue expected read data; a monitor matches each answer

`timescale 1ns/100ps

module ssef_status_flags_tb_top
  import ssef_pkg::*;
;
  localparam logic [15:0] ad_c2 = SSEF_ADDR_CONTROL_TWO;
  localparam logic [15:0] ad_c3 = SSEF_ADDR_CONTROL_THREE;
  localparam logic [15:0] ad_s1 = SSEF_ADDR_STATUS_ONE;
  localparam logic [15:0] ad_s2 = SSEF_ADDR_STATUS_TWO;
  localparam logic [15:0] ad_dat = SSEF_ADDR_DATA_BUFFER;

  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] cpu_addr = 16'h0000;
  logic        cpu_rd = 1'b0;
  logic        cpu_wr = 1'b0;
  logic [7:0]  cpu_wdata = 8'h00;
  logic        rx_enable = 1'b0;
  logic        nine_bit_mode = 1'b0;
  logic        tx_load_taken = 1'b0;
  logic        tx_busy = 1'b0;
  logic        tx_queued = 1'b0;
  logic [7:0]  cpu_rdata, rx_char_data, tx_data_out;
  logic        rx_char_done, rx_char_bit8, rx_noise, rx_frame_err, rx_parity_err;
  logic        rx_break, rx_line_high, rx_idle_char, rx_start_seen, rx_false_start;
  logic        tx_ninth_out, tx_data_valid, tx_irq, rx_irq, rx_err_irq, rx_ninth_bit;
  logic        rd_seen = 1'b0;
  logic [7:0]  exp_q[$];
  int          fail_count = 0;
  int          checks_done = 0;

  ssef_status_flags ssef_status_flags_i (
    .mclk, .sys_rst, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata,
    .rx_enable, .nine_bit_mode, .rx_char_done, .rx_char_data, .rx_char_bit8,
    .rx_noise, .rx_frame_err, .rx_parity_err, .rx_break, .rx_line_high,
    .rx_idle_char, .rx_start_seen, .rx_false_start, .tx_load_taken, .tx_busy,
    .tx_queued, .tx_data_out, .tx_ninth_out, .tx_data_valid, .tx_irq, .rx_irq,
    .rx_err_irq, .rx_ninth_bit
  );

  ssef_rx_node ssef_rx_node_i (
    .mclk, .rx_char_done, .rx_char_data, .rx_char_bit8, .rx_noise, .rx_frame_err,
    .rx_parity_err, .rx_break, .rx_line_high, .rx_idle_char, .rx_start_seen,
    .rx_false_start
  );

  // 250 MHz clock
  initial begin
    forever #2 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // Single-cycle strobes; software never does read-modify-write on data
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    cpu_addr <= a;
    cpu_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    cpu_rd   <= 1'b0;
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    cpu_addr  <= a;
    cpu_wdata <= d;
    cpu_wr    <= 1'b1;
    @(posedge mclk);
    cpu_wr    <= 1'b0;
  endtask : wr

  // Irq lines are combinational: let the edge's updates land first
  task automatic chk_irq(input logic [2:0] e);
    #1;
    check("irq", {5'h00, tx_irq, rx_irq, rx_err_irq}, {5'h00, e});
  endtask : chk_irq

  task automatic tx_ev(input logic load, input logic queued, input logic busy);
    @(posedge mclk);
    tx_load_taken <= load;
    tx_queued     <= queued;
    tx_busy       <= busy;
    @(posedge mclk);
    tx_load_taken <= 1'b0;
    tx_queued     <= 1'b0;
  endtask : tx_ev

  task automatic done(input string n);
    $display("test %s done", n);
  endtask : done

  // Monitor matches each read answer with the oldest note
  always @(posedge mclk) begin
    rd_seen <= cpu_rd;
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("Error read data expected none seen %h", cpu_rdata);
      end else begin
        check("read data", cpu_rdata, exp_q.pop_front());
      end
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    $display("Error watchdog expected finish seen timeout");
    summarize();
  end

  initial begin
    logic [7:0] b;
    logic [7:0] c;
    void'($urandom(12580));
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(ad_s1, 8'hC0);
    rd(ad_s2, 8'h00);
    rd(ad_c2, 8'h00);
    rd(16'h0020, 8'h00);
    chk_irq(3'b000);
    done("reset");
    rx_enable <= 1'b1;
    ssef_rx_node_i.pulse(9'h004, 8'hFF, 1'b1);
    rd(ad_s1, 8'hC0);
    wr(ad_c2, 8'h30);
    b = 8'($urandom());
    ssef_rx_node_i.pulse(9'h100, b, 1'b0);
    chk_irq(3'b010);
    rd(ad_s1, 8'hE0);
    rd(ad_dat, b);
    chk_irq(3'b000);
    ssef_rx_node_i.pulse(9'h004, 8'hFF, 1'b1);
    rd(ad_s1, 8'hD0);
    chk_irq(3'b010);
    rd(ad_dat, b);
    rd(ad_s1, 8'hC0);
    ssef_rx_node_i.pulse(9'h004, 8'hFF, 1'b1);
    rd(ad_s1, 8'hC0);
    // Re-enabling the receiver must disarm idle detection again
    b = 8'($urandom());
    ssef_rx_node_i.pulse(9'h100, b, 1'b0);
    rd(ad_s1, 8'hE0);
    rd(ad_dat, b);
    @(posedge mclk);
    rx_enable <= 1'b0;
    @(posedge mclk);
    rx_enable <= 1'b1;
    ssef_rx_node_i.pulse(9'h004, 8'hFF, 1'b1);
    rd(ad_s1, 8'hC0);
    done("receive and idle");
    ssef_rx_node_i.pulse(9'h002, 8'h00, 1'b0);
    rd(ad_s2, 8'h01);
    ssef_rx_node_i.pulse(9'h001, 8'h00, 1'b0);
    rd(ad_s2, 8'h00);
    ssef_rx_node_i.pulse(9'h002, 8'h00, 1'b0);
    ssef_rx_node_i.pulse(9'h004, 8'hFF, 1'b1);
    rd(ad_s2, 8'h00);
    rd(ad_s1, 8'hC0);
    done("in progress");
    b = 8'($urandom());
    c = 8'($urandom());
    ssef_rx_node_i.pulse(9'h100, b, 1'b0);
    ssef_rx_node_i.pulse(9'h100, ~b, 1'b0);
    rd(ad_s1, 8'hE8);
    rd(ad_dat, b);
    rd(ad_s1, 8'hC0);
    ssef_rx_node_i.pulse(9'h100, c, 1'b0);
    rd(ad_s1, 8'hE0);
    ssef_rx_node_i.pulse(9'h100, ~c, 1'b0);
    rd(ad_dat, c);
    rd(ad_s1, 8'hC8);
    rd(ad_dat, c);
    rd(ad_s1, 8'hC0);
    done("overrun");
    wr(ad_c2, 8'h00);
    for (int k = 0; k < 4; k++) begin
      b = 8'($urandom());
      ssef_rx_node_i.pulse((k == 3) ? 9'h100 : (9'h100 | (9'h020 << k)), b, 1'b0);
      if (k == 3)
        ssef_rx_node_i.pulse(9'h100, ~b, 1'b0);
      wr(ad_c3, 8'h0F ^ (8'h01 << k));
      chk_irq(3'b000);
      wr(ad_c3, 8'h01 << k);
      chk_irq(3'b001);
      rd(ad_s1, 8'hE0 | (8'h01 << k));
      rd(ad_dat, b);
      rd(ad_s1, 8'hC0);
      chk_irq(3'b000);
    end
    done("error enables");
    nine_bit_mode <= 1'b1;
    b = 8'($urandom());
    ssef_rx_node_i.pulse(9'h100, b, 1'b1);
    #1;
    check("ninth bit", {7'h00, rx_ninth_bit}, 8'h01);
    rd(ad_s1, 8'hE0);
    rd(ad_dat, b);
    ssef_rx_node_i.pulse(9'h010, 8'hFF, 1'b1);
    #1;
    check("ninth bit", {7'h00, rx_ninth_bit}, 8'h00);
    chk_irq(3'b000);
    rd(ad_s1, 8'hE2);
    rd(ad_s2, 8'h02);
    rd(ad_dat, 8'h00);
    rd(ad_s1, 8'hC0);
    rd(ad_s2, 8'h00);
    ssef_rx_node_i.pulse(9'h010, 8'hFF, 1'b1);
    rd(ad_s2, 8'h00);
    ssef_rx_node_i.pulse(9'h008, 8'hFF, 1'b1);
    ssef_rx_node_i.pulse(9'h010, 8'hFF, 1'b1);
    rd(ad_s2, 8'h02);
    rd(ad_s1, 8'hE2);
    rd(ad_dat, 8'h00);
    rd(ad_s2, 8'h00);
    nine_bit_mode <= 1'b0;
    done("break");
    wr(ad_c2, 8'hC0);
    chk_irq(3'b100);
    rd(ad_s1, 8'hC0);
    b = 8'($urandom());
    wr(ad_dat, b);
    #1;
    check("tx data", tx_data_out, b);
    check("tx valid", {7'h00, tx_data_valid}, 8'h01);
    chk_irq(3'b000);
    rd(ad_s1, 8'h00);
    tx_ev(1'b1, 1'b0, 1'b1);
    rd(ad_s1, 8'h80);
    chk_irq(3'b100);
    tx_ev(1'b0, 1'b0, 1'b0);
    rd(ad_s1, 8'hC0);
    tx_ev(1'b0, 1'b1, 1'b1);
    rd(ad_s1, 8'h80);
    tx_ev(1'b0, 1'b0, 1'b0);
    wr(ad_c3, 8'h40);
    #1;
    check("tx ninth", {7'h00, tx_ninth_out}, 8'h01);
    done("transmit");
    c = 8'($urandom());
    ssef_rx_node_i.pulse(9'h100, c, 1'b0);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(ad_dat, c);
    rd(ad_s1, 8'hC0);
    rd(ad_c3, {c[7], 7'h00});
    repeat (3) @(posedge mclk);
    check("queue", 8'(exp_q.size()), 8'h00);
    done("second reset");
    summarize();
  end
endmodule : ssef_status_flags_tb_top
